// ---- hw/afs_status.sv ----
/*
 * ALU condition and control status plus float exception status.
 * Holds both status registers, computes the ALU add and its flags,
 * and serves special-register reads and writes.
 * Assumes instruction, load/store and float events arrive one per
 * cycle from logic on the same clock, already decoded.
 */
`timescale 1ns/1ns
`default_nettype none

`include "afs_map.svh"

module afs_status
    import afs_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    // Execution unit operation
    input  wire afs_inst_s         inst_in,
    // Load or store with its selector bit
    input  wire logic              ls_valid_in,
    input  wire logic              latch_byte_select_in,
    // Float exception report
    input  wire afs_fp_s           fp_in,
    // Special-register write and read
    input  wire afs_spr_s          spr_wr_in,
    input  wire logic [7:0]        spr_rd_addr_in,
    // Results
    output logic      [WIDTH-1:0]  result_out,
    output logic                   result_valid_out,
    output logic                   fp_trap_out,
    output logic      [31:0]       rd_data_out,
    // Live status words
    output logic      [31:0]       alu_status_out,
    output logic      [31:0]       fps_status_out
);

    afs_state_s  st;
    afs_state_s  next_st;

    logic [31:0] add_b;
    logic        add_cin;
    logic [31:0] sum;
    logic        cout;
    logic        cmsb;
    logic [31:0] shift_res;
    logic [31:0] logic_res;
    logic [31:0] written;
    logic        is_arith;
    logic        is_logic;
    logic        is_step;
    logic [5:0]  unmasked;
    logic        trap_now;
    logic        wr_alu;
    logic        wr_fps;
    logic        wr_bsel;
    logic        wr_shamt;

    // Status word packing, unused positions forced to zero
    function automatic logic [31:0] pack_alu(input afs_alu_s f);
        logic [31:0] w;
        w = 32'h0;
        w[`AFS_QDIR_BIT]              = f.qdir;
        w[`AFS_OVF_BIT]               = f.ovf;
        w[`AFS_NEG_BIT]               = f.neg;
        w[`AFS_ZERO_BIT]              = f.zero;
        w[`AFS_CARRY_BIT]             = f.carry;
        w[`AFS_BSEL_HI:`AFS_BSEL_LO]  = f.bsel;
        w[`AFS_SHAMT_HI:`AFS_SHAMT_LO] = f.shamt;
        return w;
    endfunction

    function automatic logic [31:0] pack_fps(input afs_fps_s f);
        logic [31:0] w;
        w = 32'h0;
        w[`AFS_TRAP_HI:`AFS_TRAP_LO]     = f.trap_bits;
        w[`AFS_STICKY_HI:`AFS_STICKY_LO] = f.sticky;
        return w;
    endfunction

    // Shared adder for arithmetic, steps and the division end
    afs_adder #(
        .WIDTH (32)
    ) u_adder (
        .a_in     (inst_in.a),
        .b_in     (add_b),
        .cin_in   (add_cin),
        .sum_out  (sum),
        .cout_out (cout),
        .cmsb_out (cmsb)
    );

    // Funnel and byte lane unit, steered by the held fields
    afs_shifter u_shifter (
        .op_in      (inst_in.op),
        .amount_in  (st.alu.shamt),
        .bsel_in    (st.alu.bsel),
        .hi_in      (inst_in.a),
        .lo_in      (inst_in.b),
        .result_out (shift_res)
    );

    // Write decode for the special registers
    always_comb begin
        wr_alu   = spr_wr_in.en && (spr_wr_in.addr == `AFS_ALU_REG);
        wr_fps   = spr_wr_in.en && (spr_wr_in.addr == `AFS_FPS_REG);
        wr_bsel  = spr_wr_in.en && (spr_wr_in.addr == `AFS_BSEL_REG);
        wr_shamt = spr_wr_in.en && (spr_wr_in.addr == `AFS_SHAMT_REG);
    end

    // Adder operand: subtraction adds a complement of b
    always_comb begin
        add_b   = inst_in.b;
        add_cin = 1'b0;
        case (inst_in.op)
            AFS_OP_ADDC: begin
                add_cin = st.alu.carry;
            end
            AFS_OP_SUB: begin
                add_b   = ~inst_in.b;
                add_cin = 1'b1;
            end
            AFS_OP_SUBC: begin
                add_b   = ~inst_in.b;
                add_cin = st.alu.carry;
            end
            AFS_OP_MSTEP: begin
                add_b   = inst_in.aux ? inst_in.b : 32'h0;
            end
            AFS_OP_DSTEP,
            AFS_OP_DIVEND: begin
                // Direction bit set means subtract the divisor
                add_b   = st.alu.qdir ? ~inst_in.b : inst_in.b;
                add_cin = st.alu.qdir;
            end
            default: begin
                add_b   = inst_in.b;
                add_cin = 1'b0;
            end
        endcase
    end

    // Class of the operation and the word that goes to the register file
    always_comb begin
        is_arith  = 1'b0;
        is_logic  = 1'b0;
        is_step   = 1'b0;
        logic_res = 32'h0;
        written   = sum;
        case (inst_in.op)
            AFS_OP_ADD, AFS_OP_ADDC,
            AFS_OP_SUB, AFS_OP_SUBC: begin
                is_arith = 1'b1;
            end
            AFS_OP_MSTEP: begin
                // Multiply step shifts right, carry enters on top
                is_arith = 1'b1;
                is_step  = 1'b1;
                written  = {cout, sum[31:1]};
            end
            AFS_OP_DSTEP, AFS_OP_DIVEND: begin
                // Divide step shifts left, quotient bit enters below
                is_arith = 1'b1;
                is_step  = 1'b1;
                written  = {sum[30:0], inst_in.aux};
            end
            AFS_OP_AND: begin
                is_logic  = 1'b1;
                logic_res = inst_in.a & inst_in.b;
                written   = logic_res;
            end
            AFS_OP_OR: begin
                is_logic  = 1'b1;
                logic_res = inst_in.a | inst_in.b;
                written   = logic_res;
            end
            AFS_OP_XOR: begin
                is_logic  = 1'b1;
                logic_res = inst_in.a ^ inst_in.b;
                written   = logic_res;
            end
            AFS_OP_EXTRACT, AFS_OP_EXBYTE, AFS_OP_EXHALF,
            AFS_OP_EXHALFS, AFS_OP_INSBYTE: begin
                written = shift_res;
            end
            default: begin
                written = sum;
            end
        endcase
    end

    // Float exception trap decision: any unmasked exception traps
    always_comb begin
        unmasked = fp_in.exc & ~fp_in.mask;
        trap_now = fp_in.valid && (unmasked != 6'h0);
    end

    // Next state; software writes first, hardware events override
    always_comb begin
        next_st              = st;
        next_st.trap         = 1'b0;
        next_st.result_valid = 1'b0;

        // Whole status register write loads every field
        if (wr_alu) begin
            next_st.alu.qdir  = spr_wr_in.data[`AFS_QDIR_BIT];
            next_st.alu.ovf   = spr_wr_in.data[`AFS_OVF_BIT];
            next_st.alu.neg   = spr_wr_in.data[`AFS_NEG_BIT];
            next_st.alu.zero  = spr_wr_in.data[`AFS_ZERO_BIT];
            next_st.alu.carry = spr_wr_in.data[`AFS_CARRY_BIT];
            next_st.alu.bsel  =
                spr_wr_in.data[`AFS_BSEL_HI:`AFS_BSEL_LO];
            next_st.alu.shamt =
                spr_wr_in.data[`AFS_SHAMT_HI:`AFS_SHAMT_LO];
        end
        if (wr_bsel) begin
            next_st.alu.bsel = spr_wr_in.data[1:0];
        end
        if (wr_shamt) begin
            next_st.alu.shamt = spr_wr_in.data[4:0];
        end

        // Flagged load or store forces the selector to the last byte
        if (ls_valid_in && latch_byte_select_in) begin
            next_st.alu.bsel = `AFS_LS_BSEL;
        end

        // Condition flags from the add, zero from the written word; logic ops set only neg and zero, other classes leave them alone
        if (inst_in.valid && is_arith) begin
            next_st.alu.ovf   = cout ^ cmsb;
            next_st.alu.neg   = sum[31];
            next_st.alu.zero  = (written == 32'h0);
            next_st.alu.carry = cout;
        end else if (inst_in.valid && is_logic) begin
            next_st.alu.neg   = logic_res[31];
            next_st.alu.zero  = (logic_res == 32'h0);
        end

        // Division end: forced one or the inverted 33rd adder bit
        if (inst_in.valid && (inst_in.op == AFS_OP_DIVEND)) begin
            next_st.alu.qdir = inst_in.aux ? 1'b1 : ~cout;
        end

        // Result word goes out with a one-cycle valid
        if (inst_in.valid && (inst_in.op != AFS_OP_NONE)) begin
            next_st.result       = written;
            next_st.result_valid = 1'b1;
        end

        // Software write to the float status replaces both groups
        if (wr_fps) begin
            next_st.float_exception_status.trap_bits =
                spr_wr_in.data[`AFS_TRAP_HI:`AFS_TRAP_LO];
            next_st.float_exception_status.sticky    =
                spr_wr_in.data[`AFS_STICKY_HI:`AFS_STICKY_LO];
        end

        // Trap bits follow only a trapping operation, whole group at once
        if (trap_now) begin
            next_st.float_exception_status.trap_bits = fp_in.exc;
            next_st.trap          = 1'b1;
        end

        // Masked exceptions accumulate; set beats a same-cycle clear
        if (fp_in.valid) begin
            next_st.float_exception_status.sticky = next_st.float_exception_status.sticky
                               | (fp_in.exc & fp_in.mask);
        end

        // Read data reflects the state before this cycle's updates
        case (spr_rd_addr_in)
            `AFS_ALU_REG:   next_st.rd_data = pack_alu(st.alu);
            `AFS_FPS_REG:   next_st.rd_data = pack_fps(st.float_exception_status);
            `AFS_BSEL_REG:  next_st.rd_data = {30'h0, st.alu.bsel};
            `AFS_SHAMT_REG: next_st.rd_data = {27'h0, st.alu.shamt};
            default:        next_st.rd_data = 32'h0;
        endcase
    end

    // All state in one register bank
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st.alu          <= `AFS_ALU_RESET;
            st.float_exception_status          <= `AFS_FPS_RESET;
            st.result       <= 32'h0;
            st.result_valid <= 1'b0;
            st.trap         <= 1'b0;
            st.rd_data      <= 32'h0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs are flop bits; packing adds only constant zeros
    assign result_out       = st.result;
    assign result_valid_out = st.result_valid;
    assign fp_trap_out      = st.trap;
    assign rd_data_out      = st.rd_data;
    assign alu_status_out   = pack_alu(st.alu);
    assign fps_status_out   = pack_fps(st.float_exception_status);

endmodule

`default_nettype wire

// ---- hw/afs_map.svh ----
/*
 * Register numbers, field positions, reset values and fixed codes
 * for the ALU and float status block.
 * Assumes inclusion by bare name from the top module, the checker and the bench.
 */
`ifndef AFS_MAP_SVH
`define AFS_MAP_SVH

// Special-register numbers
`define AFS_ALU_REG      8'h84
`define AFS_FPS_REG      8'ha2
`define AFS_BSEL_REG     8'h85
`define AFS_SHAMT_REG    8'h86

// ALU status field positions
`define AFS_QDIR_BIT     11
`define AFS_OVF_BIT      10
`define AFS_NEG_BIT      9
`define AFS_ZERO_BIT     8
`define AFS_CARRY_BIT    7
`define AFS_BSEL_HI      6
`define AFS_BSEL_LO      5
`define AFS_SHAMT_HI     4
`define AFS_SHAMT_LO     0

// Float status field positions
`define AFS_TRAP_HI      13
`define AFS_TRAP_LO      8
`define AFS_STICKY_HI    5
`define AFS_STICKY_LO    0

// Reset values and fixed codes
`define AFS_ALU_RESET    12'h000
`define AFS_FPS_RESET    12'h000
`define AFS_LS_BSEL      2'h3

`endif

// ---- hw/afs_pkg.sv ----
/*
 * Types shared by the ALU and float status block.
 * Assumes the constants of afs_map.svh for all figures.
 */
package afs_pkg;

    // Operation classes handed in by the execution unit
    typedef enum logic [3:0] {
        AFS_OP_NONE    = 4'h0,
        AFS_OP_ADD     = 4'h1,
        AFS_OP_ADDC    = 4'h2,
        AFS_OP_SUB     = 4'h3,
        AFS_OP_SUBC    = 4'h4,
        AFS_OP_MSTEP   = 4'h5,
        AFS_OP_DSTEP   = 4'h6,
        AFS_OP_AND     = 4'h7,
        AFS_OP_OR      = 4'h8,
        AFS_OP_XOR     = 4'h9,
        AFS_OP_DIVEND  = 4'ha,
        AFS_OP_EXTRACT = 4'hb,
        AFS_OP_EXBYTE  = 4'hc,
        AFS_OP_EXHALF  = 4'hd,
        AFS_OP_EXHALFS = 4'he,
        AFS_OP_INSBYTE = 4'hf
    } afs_op_e;

    typedef struct packed {
        logic        valid;
        afs_op_e     op;
        logic        aux;
        logic [31:0] a;
        logic [31:0] b;
    } afs_inst_s;

    typedef struct packed {
        logic       valid;
        logic [5:0] exc;
        logic [5:0] mask;
    } afs_fp_s;

    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [31:0] data;
    } afs_spr_s;

    typedef struct packed {
        logic       qdir;
        logic       ovf;
        logic       neg;
        logic       zero;
        logic       carry;
        logic [1:0] bsel;
        logic [4:0] shamt;
    } afs_alu_s;

    typedef struct packed {
        logic [5:0] trap_bits;
        logic [5:0] sticky;
    } afs_fps_s;

    typedef struct packed {
        afs_alu_s    alu;
        afs_fps_s    float_exception_status;
        logic [31:0] result;
        logic        result_valid;
        logic        trap;
        logic [31:0] rd_data;
    } afs_state_s;

endpackage

// ---- hw/afs_adder.sv ----
/*
 * Adder that also reports the carry into its top bit.
 * Assumes operands already complemented by the caller.
 */
`timescale 1ns/1ns
`default_nettype none

module afs_adder #(
    parameter int WIDTH = 32
) (
    // Operands
    input  wire logic [WIDTH-1:0] a_in,
    input  wire logic [WIDTH-1:0] b_in,
    input  wire logic             cin_in,
    // Results
    output logic      [WIDTH-1:0] sum_out,
    output logic                  cout_out,
    output logic                  cmsb_out
);

    logic [WIDTH-1:0] low;
    logic [1:0]       top;

    // Split add exposes the carry into the top bit
    always_comb begin
        low      = {1'b0, a_in[WIDTH-2:0]} + {1'b0, b_in[WIDTH-2:0]}
                   + {{(WIDTH-1){1'b0}}, cin_in};
        top      = {1'b0, a_in[WIDTH-1]} + {1'b0, b_in[WIDTH-1]}
                   + {1'b0, low[WIDTH-1]};
        sum_out  = {top[0], low[WIDTH-2:0]};
        cout_out = top[1];
        cmsb_out = low[WIDTH-1];
    end

endmodule

`default_nettype wire

// ---- hw/afs_shifter.sv ----
/*
 * Funnel extract, byte insert, and byte or half-word extract.
 * Assumes big-endian byte order: selector 0 is the top byte.
 */
`timescale 1ns/1ns
`default_nettype none

module afs_shifter
    import afs_pkg::*;
(
    // Control
    input  wire afs_op_e     op_in,
    input  wire logic [4:0]  amount_in,
    input  wire logic [1:0]  bsel_in,
    // Operands
    input  wire logic [31:0] hi_in,
    input  wire logic [31:0] lo_in,
    // Result
    output logic      [31:0] result_out
);

    logic [63:0] joined;
    logic [4:0]  bshift;
    logic [31:0] half;

    // Right shift that brings a byte lane down to the bottom
    function automatic logic [4:0] lane_shift(input logic [1:0] sel);
        lane_shift = {~sel, 3'h0};
    endfunction

    always_comb begin
        joined = {hi_in, lo_in} << amount_in;
        bshift = lane_shift(bsel_in);
        half   = bsel_in[1] ? {16'h0, hi_in[15:0]}
                            : {16'h0, hi_in[31:16]};
        case (op_in)
            AFS_OP_EXTRACT: result_out = joined[63:32];
            AFS_OP_EXBYTE:  result_out = {24'h0, 8'(hi_in >> bshift)};
            AFS_OP_EXHALF:  result_out = half;
            AFS_OP_EXHALFS: result_out = {{16{half[15]}}, half[15:0]};
            AFS_OP_INSBYTE: result_out = (hi_in & ~(32'hff << bshift))
                                       | ({24'h0, lo_in[7:0]} << bshift);
            default:        result_out = 32'h0;
        endcase
    end

endmodule

`default_nettype wire

// ---- test/afs_status_assertions.sv ----
/*
 * Port-level checker for the ALU and float status block.
 * Assumes the single core clock and the active-low reset of afs_status.
 */
`timescale 1ns/1ns
`default_nettype none

`include "afs_map.svh"

module afs_status_assertions
    import afs_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    // Watched inputs
    input  wire afs_inst_s        inst_in,
    input  wire logic             ls_valid_in,
    input  wire logic             latch_byte_select_in,
    input  wire afs_fp_s          fp_in,
    input  wire afs_spr_s         spr_wr_in,
    input  wire logic [7:0]       spr_rd_addr_in,
    // Watched outputs
    input  wire logic [WIDTH-1:0] result_out,
    input  wire logic             result_valid_out,
    input  wire logic             fp_trap_out,
    input  wire logic [31:0]      rd_data_out,
    input  wire logic [31:0]      alu_status_out,
    input  wire logic [31:0]      fps_status_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Reference values for one-edge lookback
    logic [32:0] add_ref;
    logic [5:0]  fp_masked;
    logic        fp_unmasked;
    assign add_ref     = {1'b0, inst_in.a} + {1'b0, inst_in.b};
    assign fp_masked   = fp_in.exc & fp_in.mask;
    assign fp_unmasked = fp_in.valid && ((fp_in.exc & ~fp_in.mask) != 6'h00);

    // Logical op with no competing selector or register traffic
    sequence s_logic_op;
        inst_in.valid && !spr_wr_in.en && !ls_valid_in
            && (inst_in.op inside {AFS_OP_AND, AFS_OP_OR, AFS_OP_XOR});
    endsequence
    sequence s_logic_flags;
        alu_status_out[9] == result_out[31] && alu_status_out[8] == (result_out == '0)
            && alu_status_out[10] == $past(alu_status_out[10])
            && alu_status_out[7] == $past(alu_status_out[7]);
    endsequence

    property p_add_result;
        inst_in.valid && inst_in.op == AFS_OP_ADD |=> {alu_status_out[7], result_out} == $past(add_ref);
    endproperty
    property p_logic_flags;
        s_logic_op |=> s_logic_flags;
    endproperty
    property p_result_valid;
        inst_in.valid && inst_in.op != AFS_OP_NONE |=> result_valid_out;
    endproperty
    property p_result_quiet;
        !inst_in.valid |=> !result_valid_out;
    endproperty
    property p_trap_load;
        fp_unmasked |=> fp_trap_out && fps_status_out[13:8] == $past(fp_in.exc);
    endproperty
    property p_no_trap;
        fp_in.valid && !fp_unmasked && !spr_wr_in.en |=> !fp_trap_out && $stable(fps_status_out[13:8]);
    endproperty
    property p_sticky_set;
        fp_in.valid |=> (fps_status_out[5:0] & $past(fp_masked)) == $past(fp_masked);
    endproperty
    property p_sticky_hold;
        !fp_in.valid && !spr_wr_in.en |=> $stable(fps_status_out[5:0]);
    endproperty
    property p_reserved_zero;
        alu_status_out[31:12] == 20'h0 && fps_status_out[31:14] == 18'h0 && fps_status_out[7:6] == 2'h0;
    endproperty
    property p_ls_selector;
        ls_valid_in && latch_byte_select_in |=> alu_status_out[6:5] == `AFS_LS_BSEL;
    endproperty
    property p_shamt_hold;
        !(spr_wr_in.en && (spr_wr_in.addr inside {`AFS_ALU_REG, `AFS_SHAMT_REG}))
            |=> $stable(alu_status_out[4:0]);
    endproperty

    a_add_result: assert property (p_add_result) else $error("add result wrong");
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");
    a_result_valid: assert property (p_result_valid) else $error("no result valid");
    a_result_quiet: assert property (p_result_quiet) else $error("stray valid");
    a_trap_load: assert property (p_trap_load) else $error("trap bits not loaded");
    a_no_trap: assert property (p_no_trap) else $error("trap bits moved");
    a_sticky_set: assert property (p_sticky_set) else $error("sticky not set");
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky changed");
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");
    a_ls_selector: assert property (p_ls_selector) else $error("selector not set");
    a_shamt_hold: assert property (p_shamt_hold) else $error("shift changed");
endmodule

bind afs_status afs_status_assertions #(.WIDTH(WIDTH)) i_afs_status_assertions (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .inst_in(inst_in),
    .ls_valid_in(ls_valid_in), .latch_byte_select_in(latch_byte_select_in),
    .fp_in(fp_in), .spr_wr_in(spr_wr_in), .spr_rd_addr_in(spr_rd_addr_in),
    .result_out(result_out), .result_valid_out(result_valid_out),
    .fp_trap_out(fp_trap_out), .rd_data_out(rd_data_out),
    .alu_status_out(alu_status_out), .fps_status_out(fps_status_out)
);

`default_nettype wire

// ---- test/alu_fp_status_flags_test.sv ----
/*
 * Self-checking bench: register moves, ALU operations, float reports.
 * Assumes the checker file is compiled alongside and binds itself.
 */
`timescale 1ns/1ns
`default_nettype none

`include "afs_map.svh"

module alu_fp_status_flags_test
    import afs_pkg::*;
;
    // Stimulus, outputs and expected state
    logic        core_clk_in, rst_n_in, ls_valid_in, latch_byte_select_in;
    afs_inst_s   inst_in;
    afs_fp_s     fp_in;
    afs_spr_s    spr_wr_in;
    logic [7:0]  spr_rd_addr_in;
    logic [31:0] result_out, rd_data_out, alu_status_out, fps_status_out;
    logic        result_valid_out, fp_trap_out;
    logic [11:0] ea;
    logic [5:0]  et, es;
    int          err_count, samples_checked;

    afs_status #(.WIDTH(32)) i_afs_status (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .inst_in(inst_in),
        .ls_valid_in(ls_valid_in), .latch_byte_select_in(latch_byte_select_in),
        .fp_in(fp_in), .spr_wr_in(spr_wr_in), .spr_rd_addr_in(spr_rd_addr_in),
        .result_out(result_out), .result_valid_out(result_valid_out),
        .fp_trap_out(fp_trap_out), .rd_data_out(rd_data_out),
        .alu_status_out(alu_status_out), .fps_status_out(fps_status_out)
    );

    // 20 MHz core clock
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Register moves: request held for exactly one edge
    task automatic spr_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge core_clk_in);
        spr_wr_in <= '{1'b1, addr, data};
        @(posedge core_clk_in);
        spr_wr_in.en <= 1'b0;
    endtask

    task automatic spr_read(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge core_clk_in);
        spr_rd_addr_in <= addr;
        @(posedge core_clk_in);
        #1 check(rd_data_out, exp);
    endtask

    task automatic ls_op(input logic sel);
        @(posedge core_clk_in);
        ls_valid_in <= 1'b1;
        latch_byte_select_in <= sel;
        @(posedge core_clk_in);
        ls_valid_in <= 1'b0;
        if (sel) ea[6:5] = 2'h3;
        #1 check(alu_status_out, {20'h0, ea});
    endtask

    // One operation; x is the expected result of ops outside the adder and the logic ops
    task automatic run_op(input afs_op_e op, input logic aux, input logic [31:0] a,
                          input logic [31:0] b, input logic [31:0] x);
        logic [31:0] bb, r;
        logic [32:0] s;
        logic        cin;
        bb = (op == AFS_OP_MSTEP && !aux) ? 32'h0 : b;
        cin = (op == AFS_OP_ADDC) ? ea[7] : 1'b0;
        if (op inside {AFS_OP_SUB, AFS_OP_SUBC}
            || (op inside {AFS_OP_DSTEP, AFS_OP_DIVEND} && ea[11])) begin
            bb = ~b;
            cin = (op == AFS_OP_SUBC) ? ea[7] : 1'b1;
        end
        s = {1'b0, a} + {1'b0, bb} + {32'h0, cin};
        r = (op == AFS_OP_MSTEP) ? s[32:1]
            : (op inside {AFS_OP_DSTEP, AFS_OP_DIVEND}) ? {s[30:0], aux} : s[31:0];
        if (op inside {AFS_OP_AND, AFS_OP_OR, AFS_OP_XOR}) begin
            r = (op == AFS_OP_AND) ? (a & b) : (op == AFS_OP_OR) ? (a | b) : (a ^ b);
            ea[9:8] = {r[31], r == 32'h0};
        end else if (op inside {[AFS_OP_ADD:AFS_OP_DSTEP], AFS_OP_DIVEND}) begin
            ea[10:7] = {s[32] ^ s[31] ^ a[31] ^ bb[31], s[31], r == 32'h0, s[32]};
            if (op == AFS_OP_DIVEND) ea[11] = aux | ~s[32];
        end else begin
            r = x;
        end
        @(posedge core_clk_in);
        inst_in <= '{1'b1, op, aux, a, b};
        @(posedge core_clk_in);
        inst_in.valid <= 1'b0;
        #1;
        check(result_out, r);
        check({31'h0, result_valid_out}, {31'h0, op != AFS_OP_NONE});
        check(alu_status_out, {20'h0, ea});
    endtask

    task automatic fp_op(input logic [5:0] exc, input logic [5:0] mask);
        logic trap;
        trap = (exc & ~mask) != 6'h0;
        if (trap) et = exc;
        es = es | (exc & mask);
        @(posedge core_clk_in);
        fp_in <= '{1'b1, exc, mask};
        @(posedge core_clk_in);
        fp_in.valid <= 1'b0;
        #1;
        check({31'h0, fp_trap_out}, {31'h0, trap});
        check(fps_status_out, {18'h0, et, 2'h0, es});
    endtask

    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        inst_in = '0;
        fp_in = '0;
        spr_wr_in = '0;
        spr_rd_addr_in = 8'h00;
        ls_valid_in = 1'b0;
        latch_byte_select_in = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (6) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        spr_read(`AFS_ALU_REG, 32'h0);
        spr_write(`AFS_ALU_REG, 32'hffffffff);
        spr_read(`AFS_ALU_REG, 32'h00000fff);
        spr_write(`AFS_BSEL_REG, 32'h1);
        spr_write(`AFS_SHAMT_REG, 32'h4);
        spr_write(8'h10, 32'hffffffff);
        ea = 12'hfa4;
        spr_read(`AFS_BSEL_REG, 32'h1);
        spr_read(`AFS_SHAMT_REG, 32'h4);
        spr_read(8'h10, 32'h0);
        ls_op(1'b0);
        ls_op(1'b1);
        $display("register test done");
        run_op(AFS_OP_EXBYTE, 1'b0, 32'h11223344, 32'h11223344, 32'h44);
        spr_write(`AFS_BSEL_REG, 32'h1);
        ea[6:5] = 2'h1;
        run_op(AFS_OP_EXHALF, 1'b0, 32'h11223344, 32'h11223344, 32'h1122);
        run_op(AFS_OP_EXHALFS, 1'b0, 32'h8abc0000, 32'h8abc0000, 32'hffff8abc);
        run_op(AFS_OP_INSBYTE, 1'b0, 32'h11223344, 32'haa, 32'h11aa3344);
        run_op(AFS_OP_EXTRACT, 1'b0, 32'h12345678, 32'h9abcdef0, 32'h23456789);
        run_op(AFS_OP_SUBC, 1'b0, 32'h5, 32'h3, 32'h0);
        run_op(AFS_OP_ADD, 1'b0, 32'h7fffffff, 32'h1, 32'h0);
        run_op(AFS_OP_ADDC, 1'b0, 32'hffffffff, 32'h1, 32'h0);
        run_op(AFS_OP_ADDC, 1'b0, 32'h1, 32'h1, 32'h0);
        run_op(AFS_OP_SUB, 1'b0, 32'h5, 32'h5, 32'h0);
        run_op(AFS_OP_AND, 1'b0, 32'h0f0f0f0f, 32'hf0f0f0f0, 32'h0);
        run_op(AFS_OP_OR, 1'b0, 32'h80000000, 32'h1, 32'h0);
        run_op(AFS_OP_XOR, 1'b0, 32'h12345678, 32'h12345678, 32'h0);
        run_op(AFS_OP_NONE, 1'b0, 32'h1, 32'h1, 32'h0);
        run_op(AFS_OP_DIVEND, 1'b1, 32'h5, 32'h3, 32'h0);
        run_op(AFS_OP_DSTEP, 1'b0, 32'h5, 32'h3, 32'h0);
        run_op(AFS_OP_DIVEND, 1'b0, 32'h3, 32'h5, 32'h0);
        run_op(AFS_OP_DIVEND, 1'b0, 32'h5, 32'h3, 32'h0);
        run_op(AFS_OP_DSTEP, 1'b1, 32'h5, 32'h3, 32'h0);
        run_op(AFS_OP_MSTEP, 1'b1, 32'h80000000, 32'h80000000, 32'h0);
        run_op(AFS_OP_MSTEP, 1'b0, 32'h3, 32'h7, 32'h0);
        $display("alu test done");
        spr_write(`AFS_FPS_REG, 32'hffffffff);
        spr_read(`AFS_FPS_REG, 32'h00003f3f);
        spr_write(`AFS_FPS_REG, 32'h0);
        et = 6'h00;
        es = 6'h00;
        for (int i = 0; i < 6; i++) begin
            fp_op(6'h01 << i, 6'h3f);
            fp_op(6'h01 << i, 6'h00);
        end
        fp_op(6'h21, 6'h01);
        fp_op(6'h00, 6'h00);
        spr_write(`AFS_FPS_REG, 32'h0);
        spr_read(`AFS_FPS_REG, 32'h0);
        $display("float test done");
        stop_test();
    end

    // Watchdog, far beyond the test length
    initial begin
        repeat (4000) @(posedge core_clk_in);
        err_count++;
        stop_test();
    end
endmodule

`default_nettype wire
